// *** bench/ppds_props.sv ***
`timescale 1ns/1ps
module ppds_props (
  // clock and resets
  input wire logic        I_CORE_CLK, I_RST, I_AON_RST,
  // writes and controls
  input wire logic        I_SIG_WR, I_PLAN_WR, I_RTC_WR, I_RTC_TICK,
  input wire logic        I_DEEP_SLEEP, I_WAIT_INSTR, I_WAKE_EVENT,
  input wire logic [7:0]  I_SIG_DATA,
  input wire logic [15:0] I_PLAN_DATA,
  // status
  input wire logic        O_SAFE_ACCESS, O_DCDC_BIAS_ON, O_DCDC_MODE,
  input wire logic        O_PLAN_WR_REJECT, O_SLEEP, O_SHUTDOWN,
  input wire logic        O_GLOBAL_WAKE_RESET,
  input wire logic [15:0] O_PLAN, O_RTC_VALUE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // ordered signature pair with one idle cycle between
  sequence s_unlock;
    I_SIG_WR && I_SIG_DATA == 8'h57 ##1 !I_SIG_WR
      ##1 I_SIG_WR && I_SIG_DATA == 8'hA8;
  endsequence
  // single cycle wake reset pulse
  sequence s_pulse;
    O_GLOBAL_WAKE_RESET ##1 !O_GLOBAL_WAKE_RESET;
  endsequence
  a_unlock_opens: assert property (s_unlock |=> O_SAFE_ACCESS)
    else $error("unlock pair did not open access");
  a_open_cause: assert property ($rose(O_SAFE_ACCESS) |->
    $past(I_SIG_WR) && $past(I_SIG_DATA) == 8'hA8)
    else $error("access opened without second byte");
  a_window_close: assert property ($rose(O_SAFE_ACCESS) |->
    ##[1:65] !O_SAFE_ACCESS)
    else $error("access window did not close");
  a_plan_refused: assert property (I_PLAN_WR && !O_SAFE_ACCESS |=>
    O_PLAN_WR_REJECT && $stable(O_PLAN))
    else $error("locked plan write not refused");
  a_plan_taken: assert property (I_PLAN_WR && O_SAFE_ACCESS |=>
    !O_SAFE_ACCESS && O_PLAN ==
    ($past(I_PLAN_DATA) & {$past(O_PLAN[14]), 15'h403F}))
    else $error("plan write result wrong");
  a_mode_bits: assert property ($rose(O_DCDC_MODE) |->
    $past(I_PLAN_WR) && $past(O_SAFE_ACCESS) && $past(O_DCDC_BIAS_ON))
    else $error("converter mode entered without prepared bias");
  a_pass_through: assert property ($fell(O_DCDC_BIAS_ON) |->
    !O_DCDC_MODE && $past(I_PLAN_WR) && $past(O_SAFE_ACCESS))
    else $error("converter left without protected write");
  a_sleep_pick: assert property (I_DEEP_SLEEP && I_WAIT_INSTR &&
    !O_SLEEP && !O_SHUTDOWN |=> O_SLEEP == $past(O_PLAN[4])
    && O_SHUTDOWN == !$past(O_PLAN[4]))
    else $error("wrong low-power mode chosen");
  a_wake_reset: assert property (O_SHUTDOWN && I_WAKE_EVENT
    |=> s_pulse)
    else $error("no wake reset pulse");
  a_rtc_keep: assert property (disable iff (I_AON_RST)
    !I_RTC_WR && !I_RTC_TICK |=> $stable(O_RTC_VALUE))
    else $error("rtc value changed");
endmodule : ppds_props

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  // design pins
  logic        I_CORE_CLK = 0, I_RST = 1, I_AON_RST = 1, I_DEEP_SLEEP = 0;
  logic        I_SIG_WR, I_PLAN_WR, I_RTC_WR, I_RTC_TICK;
  logic        I_WAIT_INSTR, I_WAKE_EVENT, I_FLAG_CLR;
  logic [7:0]  I_SIG_DATA;
  logic [15:0] I_PLAN_DATA, I_RTC_DATA;
  logic        O_SAFE_ACCESS, O_DCDC_BIAS_ON, O_DCDC_MODE, O_BIAS_SETTLED;
  logic        O_PLAN_WR_REJECT, O_SLEEP, O_SHUTDOWN, O_GLOBAL_WAKE_RESET;
  logic        O_RESET_CAUSE_FLAG;
  logic [15:0] O_PLAN, O_RTC_VALUE, dat = '0;
  logic [6:0]  stb = '0;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;

  // strobes and data shared by all write kinds
  assign {I_RTC_TICK, I_FLAG_CLR, I_WAKE_EVENT, I_WAIT_INSTR} = stb[6:3];
  assign {I_RTC_WR, I_PLAN_WR, I_SIG_WR} = stb[2:0];
  assign I_SIG_DATA = dat[7:0];
  assign I_PLAN_DATA = dat;
  assign I_RTC_DATA = dat;

  ppds_top DUT (
    .I_CORE_CLK          (I_CORE_CLK),
    .I_RST               (I_RST),
    .I_AON_RST           (I_AON_RST),
    .I_SIG_WR            (I_SIG_WR),
    .I_SIG_DATA          (I_SIG_DATA),
    .I_PLAN_WR           (I_PLAN_WR),
    .I_PLAN_DATA         (I_PLAN_DATA),
    .I_RTC_WR            (I_RTC_WR),
    .I_RTC_DATA          (I_RTC_DATA),
    .I_RTC_TICK          (I_RTC_TICK),
    .I_DEEP_SLEEP        (I_DEEP_SLEEP),
    .I_WAIT_INSTR        (I_WAIT_INSTR),
    .I_WAKE_EVENT        (I_WAKE_EVENT),
    .I_FLAG_CLR          (I_FLAG_CLR),
    .O_SAFE_ACCESS       (O_SAFE_ACCESS),
    .O_PLAN              (O_PLAN),
    .O_DCDC_BIAS_ON      (O_DCDC_BIAS_ON),
    .O_DCDC_MODE         (O_DCDC_MODE),
    .O_BIAS_SETTLED      (O_BIAS_SETTLED),
    .O_PLAN_WR_REJECT    (O_PLAN_WR_REJECT),
    .O_SLEEP             (O_SLEEP),
    .O_SHUTDOWN          (O_SHUTDOWN),
    .O_GLOBAL_WAKE_RESET (O_GLOBAL_WAKE_RESET),
    .O_RESET_CAUSE_FLAG  (O_RESET_CAUSE_FLAG),
    .O_RTC_VALUE         (O_RTC_VALUE)
  );

  // clock
  initial forever #4 I_CORE_CLK = ~I_CORE_CLK;

  // hang guard
  always @(posedge I_CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input string s, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk

  // one-cycle strobe: 0 sig 1 plan 2 rtc 3 wait 4 wake 5 clr 6 tick
  task automatic wr(input int k, input logic [15:0] d = '0);
    @(negedge I_CORE_CLK);
    dat = d;
    stb = 7'h01 << k;
    @(negedge I_CORE_CLK);
    stb = '0;
  endtask : wr

  task automatic unlock();
    wr(0, 16'h0057);
    wr(0, 16'h00A8);
  endtask : unlock

  initial begin
    repeat (20) @(negedge I_CORE_CLK);
    I_RST = 0;
    I_AON_RST = 0;
    chk("plan", 16'h0000, O_PLAN);
    chk("rtc", 16'h0000, O_RTC_VALUE);
    wr(1, 16'h003F);
    chk("reject", 1, O_PLAN_WR_REJECT);
    chk("plan", 0, O_PLAN);
    unlock();
    chk("open", 1, O_SAFE_ACCESS);
    wr(1, 16'hC03F);
    chk("plan", 16'h403F, O_PLAN);
    chk("bias", 1, O_DCDC_BIAS_ON);
    chk("mode", 0, O_DCDC_MODE);
    chk("settled", 0, O_BIAS_SETTLED);
    wr(1, 16'hC03F);
    chk("reject", 1, O_PLAN_WR_REJECT);
    chk("mode", 0, O_DCDC_MODE);
    repeat (1247) @(negedge I_CORE_CLK);
    chk("settled", 0, O_BIAS_SETTLED);
    @(negedge I_CORE_CLK);
    chk("settled", 1, O_BIAS_SETTLED);
    unlock();
    wr(1, 16'hC03F);
    chk("mode", 1, O_DCDC_MODE);
    chk("plan", 16'hC03F, O_PLAN);
    unlock();
    repeat (63) @(negedge I_CORE_CLK);
    chk("open", 1, O_SAFE_ACCESS);
    @(negedge I_CORE_CLK);
    chk("open", 0, O_SAFE_ACCESS);
    wr(0, 16'h0057);
    wr(0, 16'h0012);
    wr(0, 16'h00A8);
    chk("open", 0, O_SAFE_ACCESS);
    unlock();
    wr(1, 16'h0000);
    chk("plan", 0, O_PLAN);
    chk("mode", 0, O_DCDC_MODE);
    I_DEEP_SLEEP = 1;
    wr(3);
    chk("shut", 1, O_SHUTDOWN);
    wr(4);
    chk("wake", 1, O_GLOBAL_WAKE_RESET);
    chk("shut", 0, O_SHUTDOWN);
    chk("flag", 1, O_RESET_CAUSE_FLAG);
    unlock();
    wr(1, 16'h0010);
    wr(3);
    chk("sleep", 1, O_SLEEP);
    wr(4);
    chk("sleep", 0, O_SLEEP);
    chk("wake", 0, O_GLOBAL_WAKE_RESET);
    I_DEEP_SLEEP = 0;
    wr(2, 16'h12FF);
    wr(6);
    I_RST = 1;
    repeat (2) @(negedge I_CORE_CLK);
    I_RST = 0;
    chk("rtc", 16'h1300, O_RTC_VALUE);
    chk("flag", 1, O_RESET_CAUSE_FLAG);
    wr(5);
    chk("flag", 0, O_RESET_CAUSE_FLAG);
    test_done();
  end
endmodule : tb

bind ppds_top ppds_props u_props (
  .I_CORE_CLK          (I_CORE_CLK),
  .I_RST               (I_RST),
  .I_AON_RST           (I_AON_RST),
  .I_SIG_WR            (I_SIG_WR),
  .I_PLAN_WR           (I_PLAN_WR),
  .I_RTC_WR            (I_RTC_WR),
  .I_RTC_TICK          (I_RTC_TICK),
  .I_DEEP_SLEEP        (I_DEEP_SLEEP),
  .I_WAIT_INSTR        (I_WAIT_INSTR),
  .I_WAKE_EVENT        (I_WAKE_EVENT),
  .I_SIG_DATA          (I_SIG_DATA),
  .I_PLAN_DATA         (I_PLAN_DATA),
  .O_SAFE_ACCESS       (O_SAFE_ACCESS),
  .O_DCDC_BIAS_ON      (O_DCDC_BIAS_ON),
  .O_DCDC_MODE         (O_DCDC_MODE),
  .O_PLAN_WR_REJECT    (O_PLAN_WR_REJECT),
  .O_SLEEP             (O_SLEEP),
  .O_SHUTDOWN          (O_SHUTDOWN),
  .O_GLOBAL_WAKE_RESET (O_GLOBAL_WAKE_RESET),
  .O_PLAN              (O_PLAN),
  .O_RTC_VALUE         (O_RTC_VALUE)
);

// *** rtl/ppds_hold_reg.sv ***
`timescale 1ns/1ps
// register with load enable, cleared only by its own reset input
module ppds_hold_reg #(
  parameter int W = 16
) (
  // clock and clear
  input  wire logic         i_clk,
  input  wire logic         i_clr,
  // load strobe and value
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_data,
  // held value
  output logic      [W-1:0] o_data
);
  logic [W-1:0] data_q;
  logic [W-1:0] data_d;

  // next value
  always_comb begin
    data_d = data_q;
    if (i_clr) begin
      data_d = '0;
    end else if (i_load) begin
      data_d = i_data;
    end
  end

  // register
  always_ff @(posedge i_clk) begin
    data_q <= data_d;
  end

  assign o_data = data_q;
endmodule : ppds_hold_reg

// *** rtl/ppds_pkg.sv ***
//------------------------------------------------------------
//------------------------------------------------------------
package ppds_pkg;

  // unlock signature bytes
  localparam logic [7:0] SIG_FIRST  = 8'h57;
  localparam logic [7:0] SIG_SECOND = 8'hA8;

  // plan word layout
  localparam int PLAN_W        = 16;
  localparam int BIT_SYS_KEEP  = 0;
  localparam int BIT_SMALL_RAM = 1;
  localparam int BIT_LARGE_RAM = 2;
  localparam int BIT_LFCK      = 3;
  localparam int BIT_CORE      = 4;
  localparam int BIT_EXTEND    = 5;
  localparam int BIT_DCDC_PRE  = 14;
  localparam int BIT_DCDC_EN   = 15;
  localparam logic [15:0] PLAN_RST = 16'h0000;
  localparam logic [15:0] PLAN_MASK = 16'hC03F;

  // safe access window and timing
  localparam int CLK_MHZ        = 125;
  localparam int UNLOCK_WIN_CYC = 64;
  localparam int BIAS_WAIT_NS   = 10000;
  localparam int BIAS_WAIT_CYC  = (BIAS_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RTC_W          = 16;

  // unlock sequencer states
  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_HALF  = 2'b01,
    UNL_OPEN  = 2'b10
  } ppds_unl_type;

endpackage : ppds_pkg

// *** rtl/ppds_top.sv ***
`timescale 1ns/1ps
module ppds_top
  import ppds_pkg::*;
(
  // clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  // power-on reset of the always-on domain
  input  wire logic              I_AON_RST,
  // unlock signature write
  input  wire logic              I_SIG_WR,
  input  wire logic [7:0]        I_SIG_DATA,
  // plan word write
  input  wire logic              I_PLAN_WR,
  input  wire logic [PLAN_W-1:0] I_PLAN_DATA,
  // rtc register write and tick
  input  wire logic              I_RTC_WR,
  input  wire logic [RTC_W-1:0]  I_RTC_DATA,
  input  wire logic              I_RTC_TICK,
  // low-power entry and wake, reset cause flag clear
  input  wire logic              I_DEEP_SLEEP,
  input  wire logic              I_WAIT_INSTR,
  input  wire logic              I_WAKE_EVENT,
  input  wire logic              I_FLAG_CLR,
  // status
  output logic                   O_SAFE_ACCESS,
  output logic [PLAN_W-1:0]      O_PLAN,
  output logic                   O_DCDC_BIAS_ON,
  output logic                   O_DCDC_MODE,
  output logic                   O_BIAS_SETTLED,
  output logic                   O_PLAN_WR_REJECT,
  output logic                   O_SLEEP,
  output logic                   O_SHUTDOWN,
  output logic                   O_GLOBAL_WAKE_RESET,
  output logic                   O_RESET_CAUSE_FLAG,
  output logic [RTC_W-1:0]       O_RTC_VALUE
);

  //----------------------------------------------------------
  // unlock sequencer
  //----------------------------------------------------------
  ppds_unl_type unl_q, unl_d;
  logic [6:0]   win_q, win_d;
  logic         plan_ok;

  assign plan_ok = I_PLAN_WR && (unl_q == UNL_OPEN);

  // next state of safe access window
  always_comb begin
    unl_d = unl_q;
    win_d = win_q;
    unique case (unl_q)
      UNL_IDLE: begin
        if (I_SIG_WR && I_SIG_DATA == SIG_FIRST) begin
          unl_d = UNL_HALF;
        end
      end
      UNL_HALF: begin
        if (I_SIG_WR) begin
          if (I_SIG_DATA == SIG_SECOND) begin
            unl_d = UNL_OPEN;
            win_d = 7'(UNLOCK_WIN_CYC);
          end else begin
            unl_d = UNL_IDLE;
          end
        end
      end
      UNL_OPEN: begin
        win_d = win_q - 7'h1;
        if (plan_ok || win_q == 7'h1) begin
          unl_d = UNL_IDLE;
          win_d = '0;
        end
      end
      default: begin
        unl_d = UNL_IDLE;
      end
    endcase
  end

  // safe access registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      unl_q <= UNL_IDLE;
      win_q <= '0;
    end else begin
      unl_q <= unl_d;
      win_q <= win_d;
    end
  end

  //----------------------------------------------------------
  // plan word
  //----------------------------------------------------------
  logic [PLAN_W-1:0] plan_q, plan_d;
  logic [PLAN_W-1:0] wr_val;

  // protected update of plan word
  always_comb begin
    wr_val = I_PLAN_DATA & PLAN_MASK;
    // switch enable needs bias already prepared
    if (!plan_q[BIT_DCDC_PRE]) begin
      wr_val[BIT_DCDC_EN] = 1'b0;
    end
    plan_d = plan_q;
    if (plan_ok) begin
      plan_d = wr_val;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      plan_q <= PLAN_RST;
    end else begin
      plan_q <= plan_d;
    end
  end

  //----------------------------------------------------------
  // bias settle timer
  //----------------------------------------------------------
  logic [11:0] bias_cnt_q, bias_cnt_d;

  // counts time since bias-prepare went high
  always_comb begin
    bias_cnt_d = bias_cnt_q;
    if (!plan_q[BIT_DCDC_PRE]) begin
      bias_cnt_d = '0;
    end else if (bias_cnt_q != 12'(BIAS_WAIT_CYC)) begin
      bias_cnt_d = bias_cnt_q + 12'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      bias_cnt_q <= '0;
    end else begin
      bias_cnt_q <= bias_cnt_d;
    end
  end

  //----------------------------------------------------------
  // low-power entry and wake
  //----------------------------------------------------------
  logic sleep_q, sleep_d, shut_q, shut_d, gwr_q, gwr_d;
  logic flag_q, flag_d, rej_q, rej_d;

  // mode entry, wake, reset cause
  always_comb begin
    sleep_d = sleep_q;
    shut_d  = shut_q;
    gwr_d   = 1'b0;
    flag_d  = flag_q;
    rej_d   = I_PLAN_WR && !plan_ok;
    if (I_DEEP_SLEEP && I_WAIT_INSTR && !sleep_q && !shut_q) begin
      // core kept powered means sleep, otherwise shutdown
      if (plan_q[BIT_CORE]) begin
        sleep_d = 1'b1;
      end else begin
        shut_d = 1'b1;
      end
    end else if (I_WAKE_EVENT) begin
      sleep_d = 1'b0;
      if (shut_q) begin
        shut_d = 1'b0;
        gwr_d  = 1'b1;
      end
    end
    if (I_FLAG_CLR) begin
      flag_d = 1'b0;
    end
    if (gwr_d) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sleep_q <= 1'b0;
      shut_q  <= 1'b0;
      gwr_q   <= 1'b0;
      rej_q   <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      shut_q  <= shut_d;
      gwr_q   <= gwr_d;
      rej_q   <= rej_d;
    end
  end

  // cause flag lives in the always-on domain
  always_ff @(posedge I_CORE_CLK) begin
    if (I_AON_RST) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  //----------------------------------------------------------
  // rtc register, untouched by system reset
  //----------------------------------------------------------
  logic [RTC_W-1:0] rtc_val;
  logic [RTC_W-1:0] rtc_next;

  assign rtc_next = I_RTC_WR ? I_RTC_DATA : rtc_val + 16'h1;

  ppds_hold_reg #(
    .W (RTC_W)
  ) u_rtc (
    .i_clk  (I_CORE_CLK),
    .i_clr  (I_AON_RST),
    .i_load (I_RTC_WR || I_RTC_TICK),
    .i_data (rtc_next),
    .o_data (rtc_val)
  );

  //----------------------------------------------------------
  // outputs
  //----------------------------------------------------------
  assign O_SAFE_ACCESS       = (unl_q == UNL_OPEN);
  assign O_PLAN              = plan_q;
  assign O_DCDC_BIAS_ON      = plan_q[BIT_DCDC_PRE];
  assign O_DCDC_MODE         = plan_q[BIT_DCDC_EN]
                               && plan_q[BIT_DCDC_PRE];
  assign O_BIAS_SETTLED      = (bias_cnt_q == 12'(BIAS_WAIT_CYC));
  assign O_PLAN_WR_REJECT    = rej_q;
  assign O_SLEEP             = sleep_q;
  assign O_SHUTDOWN          = shut_q;
  assign O_GLOBAL_WAKE_RESET = gwr_q;
  assign O_RESET_CAUSE_FLAG  = flag_q;
  assign O_RTC_VALUE         = rtc_val;

endmodule : ppds_top
